// ===== rtl/flc_pkg.sv
// Constants and types shared by the flash LED control logic
package flc_pkg;

   // Clock rate in MHz
   localparam int CLK_MHZ = 100;

   // Serial pin latch timeout and shutdown timeout
   localparam int LATCH_TIME_US = 500;
   localparam int LATCH_CYCLES  = LATCH_TIME_US * CLK_MHZ;
   localparam int OFF_TIME_US   = 500;
   localparam int OFF_CYCLES    = OFF_TIME_US * CLK_MHZ;
   localparam int TMR_W         = 17;

   // Longest flash, cut into equal fractions
   localparam int FLASH_MAX_MS     = 1000;
   localparam int FLASH_STEPS      = 16;
   localparam int FLASH_MAX_CYCLES = FLASH_MAX_MS * 1000 * CLK_MHZ;
   localparam int FLASH_SEG_CYCLES = FLASH_MAX_CYCLES / FLASH_STEPS;
   localparam int SEG_W            = 23;

   // Sink test current phase after wake-up
   localparam int TEST_TIME_US = 20;
   localparam int TEST_CYCLES  = TEST_TIME_US * CLK_MHZ;
   localparam int TST_W        = 12;

   // Edge counts of a latched burst
   localparam logic [4:0] EDGE_ONE        = 5'h01;
   localparam logic [4:0] EDGE_DATA_LAST  = 5'h10;
   localparam logic [4:0] EDGE_ADDR_FIRST = 5'h11;
   localparam logic [4:0] EDGE_ADDR_LAST  = 5'h14;
   localparam logic [4:0] EDGE_SAT        = 5'h1F;

   // Register addresses
   localparam logic [1:0] ADDR_VIDEO_LEVEL = 2'h0;
   localparam logic [1:0] ADDR_TIMER_FRAC  = 2'h1;
   localparam logic [1:0] ADDR_CHAN_CFG    = 2'h2;
   localparam logic [1:0] ADDR_RATIO       = 2'h3;

   // Values of unprogrammed registers, as zero-based code index, and last safety timer segment
   localparam logic [3:0] DEF_VIDEO_IDX = 4'h0;
   localparam logic [3:0] DEF_TIMER_IDX = 4'h0;
   localparam logic [3:0] DEF_CHAN_IDX  = 4'h3;
   localparam logic [3:0] DEF_RATIO_IDX = 4'h3;
   localparam logic [3:0] LAST_SEG      = 4'hF;

   // Channel bits inside the configuration index
   localparam int CHAN_A_BIT = 1;
   localparam int CHAN_B_BIT = 0;

   // Operating state
   typedef enum logic [1:0] {
      FLC_VIDEO,
      FLC_FLASH,
      FLC_DONE
   } flc_state_t;

endpackage : flc_pkg

// ===== rtl/flc_ser_if.sv
// Carrier between serial receiver and control core
`timescale 1ns/1ps
interface flc_ser_if;
   logic       wr_pulse;
   logic [1:0] wr_addr;
   logic [3:0] wr_data;
   logic       enabled;
   logic       clear;

   modport rx   (output wr_pulse, wr_addr, wr_data, enabled, clear);
   modport core (input  wr_pulse, wr_addr, wr_data, enabled, clear);
endinterface : flc_ser_if

// ===== rtl/flc_serial_rx.sv
// Single-wire edge-count receiver with latch and shutdown timeouts
`timescale 1ns/1ps
module flc_serial_rx
   import flc_pkg::*;
#(
   parameter logic [TMR_W-1:0] LATCH_LIMIT = TMR_W'(LATCH_CYCLES),
   parameter logic [TMR_W-1:0] OFF_LIMIT   = TMR_W'(OFF_CYCLES)
) (
   input  logic  ref_clk,
   input  logic  rst_n,
   input  logic  serial_pin,
   flc_ser_if.rx bus
);

   logic             pin_s1;
   logic             pin_s2;
   logic             pin_prev;
   logic [TMR_W-1:0] hi_cnt;
   logic [TMR_W-1:0] lo_cnt;
   logic [4:0]       edges;
   logic [1:0]       addr;

   // Decode of the burst and the two timeouts
   wire       rise      = pin_s2 & ~pin_prev;
   wire       latch_now = pin_s2 & (hi_cnt == TMR_W'(LATCH_LIMIT - 1));
   wire       off_now   = ~pin_s2 & (lo_cnt == TMR_W'(OFF_LIMIT - 1));
   wire       is_addr   = (edges >= EDGE_ADDR_FIRST) &&
                          (edges <= EDGE_ADDR_LAST);
   wire       is_data   = (edges >= EDGE_ONE) && (edges <= EDGE_DATA_LAST);
   wire [4:0] addr_off  = edges - EDGE_ADDR_FIRST;
   wire [4:0] data_off  = edges - EDGE_ONE;

   // Pin synchroniser and edge history
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pin_s1   <= 1'b0;
         pin_s2   <= 1'b0;
         pin_prev <= 1'b0;
      end else begin
         pin_s1   <= serial_pin;
         pin_s2   <= pin_s1;
         pin_prev <= pin_s2;
      end
   end

   // High and low time counters, saturating so each fires once
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         hi_cnt <= '0;
         lo_cnt <= '0;
      end else begin
         hi_cnt <= (!pin_s2) ? '0 :
                   (hi_cnt == LATCH_LIMIT) ? hi_cnt : hi_cnt + 1'b1;
         lo_cnt <= pin_s2 ? '0 :
                   (lo_cnt == OFF_LIMIT) ? lo_cnt : lo_cnt + 1'b1;
      end
   end

   // Edge counter, address and enable state
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         edges <= '0;
         addr  <= '0;
         bus.enabled <= 1'b0;
      end else if (off_now) begin
         edges <= '0;
         addr  <= ADDR_VIDEO_LEVEL;
         bus.enabled <= 1'b0;
      end else begin
         if (latch_now)
            edges <= '0;
         else if (rise && edges != EDGE_SAT)
            edges <= edges + 1'b1;
         if (latch_now && is_addr)
            addr <= addr_off[1:0];
         if (rise)
            bus.enabled <= 1'b1;
      end
   end

   // Write strobe; bursts above twenty edges fall through here
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         bus.wr_pulse <= 1'b0;
         bus.wr_addr  <= '0;
         bus.wr_data  <= '0;
         bus.clear    <= 1'b0;
      end else begin
         bus.wr_pulse <= latch_now & is_data;
         bus.wr_addr  <= addr;
         bus.wr_data  <= data_off[3:0];
         bus.clear    <= off_now;
      end
   end

   // Checks on the burst decode and the shutdown
   a_addr_decode: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      latch_now && edges == 5'h13 |=> addr == 2'h2)
      else $error("address burst not decoded");
   a_long_ignored: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      latch_now && edges > EDGE_ADDR_LAST |=> $stable(addr) && !bus.wr_pulse)
      else $error("overlong burst took effect");
   a_off_clears: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      off_now |=> addr == 2'h0 && !bus.enabled ##1 bus.clear == 1'b0)
      else $error("shutdown did not clear address");

endmodule : flc_serial_rx

// ===== rtl/flc_control.sv
// Flash LED driver control: registers, flash sequencing, protection
//
// Contract
// - Trigger rising edge starts a flash on both sinks and the safety timer.
// - Safety timer expiry ends the flash even with trigger still high.
// - Flash ends when trigger falls, or earlier on timer expiry.
// - Timer code shortens the flash in sixteen linear fractions.
// - Throttle high during a flash drops sinks to default video level.
// - Throttle low restores full flash only while trigger high, timer live.
// - Video level code picks one of sixteen 1 dB steps.
// - Ratio code sets flash to video current ratio, 1:2 to 1:30.
// - High trigger overrides video light; flash takes over.
// - After a flash, video light stays off until shutdown and reprogram.
// - Register 2 enables each sink for video light at set currents.
// - Writing video level after trigger adjusts flash current in steps.
// - Overtemperature disables both switches; resumes automatically.
// - Overvoltage stops switching; resumes when the condition clears.
// - After wake-up, test current per sink; unpulled sinks get disabled.
// - Serial pin high past latch timeout latches address or data.
// - Bursts of 17 to 20 edges select registers 0 to 3.
// - Bursts of 1 to 16 edges store data in the selected register.
// - Latched address stays for repeated data bursts.
// - Address is 0 from the first edge after disable.
// - Unprogrammed registers read as default codes 1, 1, 4, 4.
// - Pin low past off timeout shuts down and clears data and address.
// - Timer code applies to the next flash only, then reverts.
// - Register 2 codes: off, B only, A only, both; flash uses both.
// - Video level code 1 is full current, code 16 is zero.
`timescale 1ns/1ps
module flc_control
   import flc_pkg::*;
#(
   parameter logic [TMR_W-1:0] LATCH_LIMIT = TMR_W'(LATCH_CYCLES),
   parameter logic [TMR_W-1:0] OFF_LIMIT   = TMR_W'(OFF_CYCLES),
   parameter logic [SEG_W-1:0] SEG_LIMIT   = SEG_W'(FLASH_SEG_CYCLES)
) (
   input  logic       ref_clk,
   input  logic       rst_n,
   input  logic       serial_pin,
   input  logic       flash_trigger,
   input  logic       flash_throttle_in,
   input  logic       over_temp,
   input  logic       over_volt,
   input  logic       timer_cap_grounded,
   input  logic       sink_a_low,
   input  logic       sink_b_low,
   output logic       sink_a,
   output logic       sink_b,
   output logic       flash_full,
   output logic [3:0] current_step,
   output logic [3:0] ratio_step,
   output logic       test_current,
   output logic       switch_en,
   output logic       device_enabled
);

   localparam logic [TST_W-1:0] TEST_LAST = TST_W'(TEST_CYCLES - 1);

   flc_ser_if ser ();

   // Serial receiver
   flc_serial_rx #(
      .LATCH_LIMIT (LATCH_LIMIT),
      .OFF_LIMIT   (OFF_LIMIT)
   ) u_rx (
      .ref_clk    (ref_clk),
      .rst_n      (rst_n),
      .serial_pin (serial_pin),
      .bus        (ser.rx)
   );

   // Pin synchronisers: trigger, throttle, ot, ov, cap, sink a, sink b
   logic [6:0] pins_s1;
   logic [6:0] pins_s2;
   logic       trig_prev;

   wire trig_s  = pins_s2[0];
   wire thr_s   = pins_s2[1];
   wire ot_s    = pins_s2[2];
   wire ov_s    = pins_s2[3];
   wire cap_gnd = pins_s2[4];
   wire a_low_s = pins_s2[5];
   wire b_low_s = pins_s2[6];

   wire trig_rise = trig_s & ~trig_prev;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pins_s1   <= '0;
         pins_s2   <= '0;
         trig_prev <= 1'b0;
      end else begin
         pins_s1   <= {sink_b_low, sink_a_low, timer_cap_grounded,
                       over_volt, over_temp, flash_throttle_in,
                       flash_trigger};
         pins_s2   <= pins_s1;
         trig_prev <= trig_s;
      end
   end

   // Register file: a clear programmed bit means the default code
   logic [3:0] prog;
   logic [3:0] reg_val [4];
   flc_state_t state;
   flc_state_t next_state;

   wire flash_start = trig_rise & (state != FLC_FLASH);
   wire tmr_write   = ser.wr_pulse & (ser.wr_addr == ADDR_TIMER_FRAC);

   wire [3:0] vid_idx   = prog[ADDR_VIDEO_LEVEL] ?
                          reg_val[ADDR_VIDEO_LEVEL] : DEF_VIDEO_IDX;
   wire [3:0] tmr_idx   = prog[ADDR_TIMER_FRAC] ?
                          reg_val[ADDR_TIMER_FRAC] : DEF_TIMER_IDX;
   wire [3:0] chan_idx  = prog[ADDR_CHAN_CFG] ?
                          reg_val[ADDR_CHAN_CFG] : DEF_CHAN_IDX;
   wire [3:0] ratio_idx = prog[ADDR_RATIO] ?
                          reg_val[ADDR_RATIO] : DEF_RATIO_IDX;

   // Writes win over the one-shot timer revert in the same cycle
   always_ff @(posedge ref_clk) begin
      if (!rst_n || ser.clear) begin
         prog <= '0;
      end else begin
         if (flash_start)
            prog[ADDR_TIMER_FRAC] <= 1'b0;
         if (ser.wr_pulse)
            prog[ser.wr_addr] <= 1'b1;
      end
   end

   // Stored codes; only the programmed bit decides their meaning
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         for (int i = 0; i < 4; i++)
            reg_val[i] <= '0;
      end else if (ser.wr_pulse) begin
         reg_val[ser.wr_addr] <= ser.wr_data;
      end
   end

   // Safety timer: whole fractions of the longest flash
   logic [SEG_W-1:0] seg_cnt;
   logic [3:0]       seg_num;
   logic [3:0]       run_idx;

   wire seg_end = (seg_cnt == SEG_W'(SEG_LIMIT - 1));
   wire expire  = (state == FLC_FLASH) & ~cap_gnd & seg_end &
                  (seg_num == LAST_SEG - run_idx);

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         seg_cnt <= '0;
         seg_num <= '0;
         run_idx <= DEF_TIMER_IDX;
      end else if (flash_start) begin
         seg_cnt <= '0;
         seg_num <= '0;
         run_idx <= tmr_idx;
      end else if (state == FLC_FLASH) begin
         seg_cnt <= seg_end ? '0 : seg_cnt + 1'b1;
         if (seg_end)
            seg_num <= seg_num + 1'b1;
      end
   end

   // Operating state; a grounded cap pin disables the timer
   always_comb begin
      next_state = state;
      case (state)
         FLC_VIDEO: begin
            if (trig_rise)
               next_state = FLC_FLASH;
         end
         FLC_FLASH: begin
            if (!trig_s || expire)
               next_state = FLC_DONE;
         end
         FLC_DONE: begin
            if (trig_rise)
               next_state = FLC_FLASH;
            else if (ser.clear)
               next_state = FLC_VIDEO;
         end
         default: next_state = FLC_VIDEO;
      endcase
   end

   // State register; shutdown reaches it only through next_state
   always_ff @(posedge ref_clk) begin
      if (!rst_n)
         state <= FLC_VIDEO;
      else
         state <= next_state;
   end

   // Sink test after wake-up; a sink that is not pulled low stays off
   logic       pow_prev;
   logic       testing;
   logic [TST_W-1:0] test_cnt;
   logic       ok_a;
   logic       ok_b;

   // A flash alone also wakes the part, so its sinks get tested first
   wire powered = ser.enabled | trig_s;
   wire wake    = powered & ~pow_prev;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pow_prev <= 1'b0;
         testing  <= 1'b0;
         test_cnt <= '0;
         ok_a     <= 1'b0;
         ok_b     <= 1'b0;
      end else begin
         pow_prev <= powered;
         if (wake) begin
            testing  <= 1'b1;
            test_cnt <= '0;
         end else if (testing) begin
            test_cnt <= test_cnt + 1'b1;
            if (test_cnt == TEST_LAST) begin
               testing <= 1'b0;
               ok_a    <= a_low_s;
               ok_b    <= b_low_s;
            end
         end
      end
   end

   // Output selection; throttle falls back to default video level
   wire in_flash  = (state == FLC_FLASH);
   wire throttled = in_flash & thr_s;
   wire video_on  = (state == FLC_VIDEO) & ser.enabled;

   wire next_sink_a = ~testing & ok_a &
                      (in_flash | (video_on & chan_idx[CHAN_A_BIT]));
   wire next_sink_b = ~testing & ok_b &
                      (in_flash | (video_on & chan_idx[CHAN_B_BIT]));
   wire next_flash_full = in_flash & ~thr_s;
   wire [3:0] next_current_step = throttled ? DEF_VIDEO_IDX
                                            : vid_idx;
   wire [3:0] next_ratio_step = throttled ? DEF_RATIO_IDX
                                          : ratio_idx;
   // Protection only gates the switch; state and codes are kept
   wire next_switch_en = (next_sink_a | next_sink_b | testing) &
                         ~ot_s & ~ov_s;

   // Registered outputs
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         sink_a         <= 1'b0;
         sink_b         <= 1'b0;
         flash_full     <= 1'b0;
         current_step   <= DEF_VIDEO_IDX;
         ratio_step     <= DEF_RATIO_IDX;
         test_current   <= 1'b0;
         switch_en      <= 1'b0;
         device_enabled <= 1'b0;
      end else begin
         sink_a         <= next_sink_a;
         sink_b         <= next_sink_b;
         flash_full     <= next_flash_full;
         current_step   <= next_current_step;
         ratio_step     <= next_ratio_step;
         test_current   <= testing;
         switch_en      <= next_switch_en;
         device_enabled <= ser.enabled;
      end
   end

   // Checks on the sequencing
   a_flash_start: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      state == FLC_VIDEO && trig_rise |=> state == FLC_FLASH ##1
      (seg_cnt == 1 || state != FLC_FLASH))
      else $error("trigger edge did not start flash");
   a_timer_end: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      expire |=> state == FLC_DONE ##1 !flash_full && !sink_a)
      else $error("flash outlived safety timer");
   a_trig_release: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      in_flash && !trig_s |=> state == FLC_DONE)
      else $error("flash did not end on trigger low");
   a_throttle_cut: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      in_flash && thr_s |=> !flash_full && current_step == DEF_VIDEO_IDX)
      else $error("throttle did not cut flash");
   a_throttle_back: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      in_flash && $fell(thr_s) |=> flash_full)
      else $error("flash not restored after throttle");
   a_no_video_return: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      state == FLC_DONE && !ser.clear && !trig_rise |=> state == FLC_DONE)
      else $error("video light resumed after flash");
   a_timer_revert: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      flash_start && !tmr_write |=> !prog[ADDR_TIMER_FRAC])
      else $error("timer code not reverted");
   a_chan_off: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      video_on && chan_idx == 4'h0 |=> !sink_a && !sink_b)
      else $error("sinks on with both disabled");
   a_over_temp: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      ot_s || ov_s |=> !switch_en)
      else $error("switching during fault");
   a_regs_clear: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      ser.clear |=> prog == 4'h0 ##1 ratio_step == DEF_RATIO_IDX ||
      state == FLC_FLASH)
      else $error("shutdown left programmed data");

   // Checks on the sink selection and the codes
   a_wake_test: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      wake |=> testing)
      else $error("no sink test after wake-up");
   a_test_dark: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      testing |=> test_current && !sink_a && !sink_b)
      else $error("sinks driven during the sink test");
   a_flash_both: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      in_flash && !testing && ok_a && ok_b |=> sink_a && sink_b)
      else $error("flash did not use both sinks");
   a_video_sinks: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      video_on && !testing && ok_a && chan_idx[CHAN_A_BIT] |=> sink_a)
      else $error("enabled sink stayed off in video light");
   a_done_dark: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      state == FLC_DONE |=> !sink_a && !sink_b)
      else $error("sinks lit after the flash ended");
   a_default_codes: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      prog == 4'h0 |=> current_step == DEF_VIDEO_IDX &&
      ratio_step == DEF_RATIO_IDX)
      else $error("unprogrammed codes not at defaults");
   a_level_follow: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      in_flash && !thr_s |=> current_step == $past(vid_idx))
      else $error("flash current ignores the level code");

endmodule : flc_control

// ===== tb/flc_host_model.sv
// Host controller model driving the serial, trigger and throttle pins
`timescale 1ns/1ps
module flc_host_model #(
   parameter int LAT = 40,
   parameter int OFF = 60
) (
   input  logic ref_clk,
   output logic serial_pin,
   output logic flash_trigger,
   output logic flash_throttle_in
);

   // Pins idle low, which the device reads as shutdown
   initial begin
      serial_pin        = 1'b0;
      flash_trigger     = 1'b0;
      flash_throttle_in = 1'b0;
   end

   // Wait a number of clock edges
   task automatic ticks(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : ticks

   // Edge burst, then high past the latch timeout
   // Two cycles per level so the two-flop synchroniser sees each edge
   task automatic burst(input int n);
      for (int i = 0; i < n; i++) begin
         serial_pin <= 1'b0;
         ticks(2);
         serial_pin <= 1'b1;
         ticks(2);
      end
      ticks(LAT + 8);
   endtask : burst

   // Address burst and timeout, then data burst and timeout
   task automatic write_reg(input int addr, input int code);
      burst(17 + addr);
      burst(code);
   endtask : write_reg

   // Hold the pin low past the off timeout before reprogramming
   task automatic shutdown();
      serial_pin <= 1'b0;
      ticks(OFF + 10);
   endtask : shutdown

   // Trigger level change, then time for sync and output flops
   task automatic set_trigger(input logic v);
      flash_trigger <= v;
      ticks(8);
   endtask : set_trigger

   // Throttle level change, then settle
   task automatic set_throttle(input logic v);
      flash_throttle_in <= v;
      ticks(8);
   endtask : set_throttle

endmodule : flc_host_model

// ===== tb/flash_led_control_logic_bench.sv
// Self-checking bench for the flash LED control logic
`timescale 1ns/1ps
module flash_led_control_logic_bench
   import flc_pkg::*;
;
   localparam int LAT = 40;
   localparam int OFF = 60;
   localparam int SEG = 8;

   logic       ref_clk;
   logic       rst_n;
   logic       over_temp;
   logic       over_volt;
   logic       timer_cap_grounded;
   logic       sink_a_low;
   logic       sink_b_low;
   logic       serial_pin;
   logic       flash_trigger;
   logic       flash_throttle_in;
   logic       sink_a;
   logic       sink_b;
   logic       flash_full;
   logic [3:0] current_step;
   logic [3:0] ratio_step;
   logic       test_current;
   logic       switch_en;
   logic       device_enabled;
   int         n_fail;
   int         num_checks;

   // Short timeouts keep the run small; expectations use LAT, OFF, SEG
   flc_control #(
      .LATCH_LIMIT (17'h00028),
      .OFF_LIMIT   (17'h0003C),
      .SEG_LIMIT   (23'h000008)
   ) dut_u (
      .ref_clk            (ref_clk),
      .rst_n              (rst_n),
      .serial_pin         (serial_pin),
      .flash_trigger      (flash_trigger),
      .flash_throttle_in  (flash_throttle_in),
      .over_temp          (over_temp),
      .over_volt          (over_volt),
      .timer_cap_grounded (timer_cap_grounded),
      .sink_a_low         (sink_a_low),
      .sink_b_low         (sink_b_low),
      .sink_a             (sink_a),
      .sink_b             (sink_b),
      .flash_full         (flash_full),
      .current_step       (current_step),
      .ratio_step         (ratio_step),
      .test_current       (test_current),
      .switch_en          (switch_en),
      .device_enabled     (device_enabled)
   );

   flc_host_model #(.LAT(LAT), .OFF(OFF)) host_u (
      .ref_clk           (ref_clk),
      .serial_pin        (serial_pin),
      .flash_trigger     (flash_trigger),
      .flash_throttle_in (flash_throttle_in)
   );

   // Free-running 100 MHz clock
   always #5 ref_clk = ~ref_clk;

   // Compare and count
   task automatic check(input logic [3:0] seen, input logic [3:0] exp,
                        input string what);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t: %s seen %h expected %h",
                  $time, what, seen, exp);
      end
   endtask : check

   task automatic t_defaults();
      check(current_step, 4'h0, "level default");
      check(ratio_step, 4'h3, "ratio default");
      check({3'h0, device_enabled}, 4'h0, "asleep");
      host_u.burst(6);
      check({3'h0, device_enabled}, 4'h1, "awake");
      check(current_step, 4'h5, "data to address 0");
      check({3'h0, test_current}, 4'h1, "test current");
      check({2'h0, sink_a, sink_b}, 4'h0, "sinks during test");
      host_u.ticks(TEST_CYCLES);
      check({2'h0, sink_a, sink_b}, 4'h3, "default sinks");
      $display("test defaults done");
   endtask : t_defaults

   task automatic t_regs();
      // Every level code through one address
      host_u.burst(17);
      for (int c = 1; c <= 16; c++) begin
         host_u.burst(c);
         check(current_step, 4'(c - 1), "level code");
      end
      host_u.write_reg(3, 1);
      check(ratio_step, 4'h0, "ratio 1:2");
      // Channel code minus one gives the sink pair {A,B}
      host_u.burst(19);
      for (int c = 1; c <= 4; c++) begin
         host_u.burst(c);
         check({2'h0, sink_a, sink_b}, 4'(c - 1), "channel code");
      end
      host_u.burst(21);
      check({2'h0, sink_a, sink_b}, 4'h3, "long burst");
      check(ratio_step, 4'h0, "long burst ratio");
      $display("test registers done");
   endtask : t_regs

   task automatic t_protect();
      check({3'h0, switch_en}, 4'h1, "switching");
      for (int k = 0; k < 2; k++) begin
         over_temp <= (k == 0);
         over_volt <= (k == 1);
         host_u.ticks(8);
         check({3'h0, switch_en}, 4'h0, "fault stops");
         over_temp <= 1'b0;
         over_volt <= 1'b0;
         host_u.ticks(8);
         check({3'h0, switch_en}, 4'h1, "fault cleared");
      end
      $display("test protection done");
   endtask : t_protect

   task automatic t_flash();
      timer_cap_grounded <= 1'b1;
      host_u.write_reg(2, 1);
      check({2'h0, sink_a, sink_b}, 4'h0, "video off");
      host_u.set_trigger(1'b1);
      check({1'b0, flash_full, sink_a, sink_b}, 4'h7, "flash");
      host_u.set_throttle(1'b1);
      check({1'b0, flash_full, sink_a, sink_b}, 4'h3, "throttle");
      check(current_step, 4'h0, "throttle level");
      check(ratio_step, 4'h3, "throttle ratio");
      host_u.set_throttle(1'b0);
      check({3'h0, flash_full}, 4'h1, "throttle off");
      host_u.write_reg(0, 9);
      check(current_step, 4'h8, "level in flash");
      host_u.set_trigger(1'b0);
      check({1'b0, flash_full, sink_a, sink_b}, 4'h0, "flash end");
      // Enabling both video sinks now must still leave them dark
      host_u.write_reg(2, 4);
      check({2'h0, sink_a, sink_b}, 4'h0, "no video after");
      timer_cap_grounded <= 1'b0;
      $display("test flash done");
   endtask : t_flash

   task automatic t_timer();
      // Code 15 leaves 2 of 16 segments
      host_u.write_reg(1, 15);
      host_u.set_trigger(1'b1);
      check({3'h0, flash_full}, 4'h1, "short flash on");
      host_u.ticks(2 * SEG + 8);
      check({3'h0, flash_full}, 4'h0, "timer expired");
      host_u.set_trigger(1'b0);
      host_u.set_trigger(1'b1);
      host_u.ticks(8 * SEG);
      check({3'h0, flash_full}, 4'h1, "code reverted");
      host_u.ticks(8 * SEG + 8);
      check({3'h0, flash_full}, 4'h0, "full span over");
      host_u.set_trigger(1'b0);
      $display("test timer done");
   endtask : t_timer

   task automatic t_shutdown();
      sink_b_low <= 1'b0;
      host_u.shutdown();
      check({3'h0, device_enabled}, 4'h0, "shut down");
      check(current_step, 4'h0, "level cleared");
      check(ratio_step, 4'h3, "ratio cleared");
      host_u.burst(3);
      check(current_step, 4'h2, "address 0 again");
      host_u.ticks(TEST_CYCLES);
      check({2'h0, sink_a, sink_b}, 4'h2, "sink B failed");
      // Second wake with the other sink left unpulled
      sink_a_low <= 1'b0;
      sink_b_low <= 1'b1;
      host_u.shutdown();
      host_u.burst(1);
      host_u.ticks(TEST_CYCLES);
      check({2'h0, sink_a, sink_b}, 4'h1, "sink A failed");
      $display("test shutdown done");
   endtask : t_shutdown

   // Single exit point of the run
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : conclude

   // Watchdog, well above the roughly 10000 cycles the tests need
   initial begin
      repeat (30000) @(posedge ref_clk);
      n_fail++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      conclude();
   end

   // Main sequence
   initial begin
      ref_clk            = 1'b0;
      rst_n              = 1'b0;
      over_temp          = 1'b0;
      over_volt          = 1'b0;
      timer_cap_grounded = 1'b0;
      sink_a_low         = 1'b1;
      sink_b_low         = 1'b1;
      n_fail             = 0;
      num_checks         = 0;
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      t_defaults();
      t_regs();
      t_protect();
      t_flash();
      t_timer();
      t_shutdown();
      conclude();
   end

endmodule : flash_led_control_logic_bench
